//--- common/elc_map.svh
/*
 * Constants of the event logger: widths, depth and command characters.
 * Assumes inclusion by the logger package, design files and the testbench.
 */
`ifndef ELC_MAP_SVH
`define ELC_MAP_SVH

`define ELC_MON_W      16
`define ELC_TS_W       32
`define ELC_REC_W      48
`define ELC_ADDR_W     12
`define ELC_CNT_W      13
`define ELC_DEPTH      13'h1000
`define ELC_LAST_ADDR  12'hfff
`define ELC_REC_CHARS  4'hc
`define ELC_CNT_CHARS  4'h4
`define ELC_CMD_START  8'h53
`define ELC_CMD_STOP   8'h50
`define ELC_CMD_COUNT  8'h4e
`define ELC_CMD_DUMP   8'h44
`define ELC_CHR_SEP    8'h3b
`define ELC_CHR_ZERO   8'h30
`define ELC_CHR_ALPHA  8'h37
`define ELC_CHR_LO     8'h20
`define ELC_CHR_HI     8'h7e

`endif

//--- common/elc_pkg.sv
/*
 * Types of the event logger: watched signal set, record and control states.
 * Assumes elc_map.svh on the include path.
 */
`include "elc_map.svh"

package elc_pkg;

    typedef struct packed {
        logic        beam_gate;
        logic        rf_gate;
        logic [13:0] ctrl_bits;
    } elc_mon_t;

    typedef struct packed {
        elc_mon_t              mon;
        logic [`ELC_TS_W-1:0]  stamp;
    } elc_rec_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DL_ADDR,
        ST_DL_LOAD,
        ST_SEND
    } elc_state_t;

endpackage : elc_pkg

//--- hdl/elc_logger.sv
/*
 * Change-triggered event logger with ASCII command and reply byte stream.
 * Assumes watched signals arrive from pins, byte stream from a same-clock
 * serial transceiver.
 */
// Functional notes
// - Any watched bit change during capture creates a record
// - Record holds all watched bits plus timestamp
// - 4096 records, oldest overwritten on wrap
// - Capture starts and stops only by command
// - No local controls, serial access only
// - Commands and replies are printable ASCII only
// - Start inhibit timers before taking the snapshot
// - RF and beam gating edges are watched
// - Start, stop, count query, then download all
// - Each board logs its own local signals
`timescale 1ns/10ps
`include "elc_map.svh"

module elc_logger (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire elc_pkg::elc_mon_t mon_in,
    input  wire logic [7:0]       rx_data,
    input  wire logic             rx_valid,
    input  wire logic             tx_ready,
    output      logic [7:0]       tx_data_q,
    output      logic             tx_valid_q,
    output      logic [1:0]       inhibit_start_q,
    output      logic             logging_q
);

    typedef struct packed {
        elc_pkg::elc_mon_t        sync1;
        elc_pkg::elc_mon_t        sync2;
        elc_pkg::elc_mon_t        prev;
        logic                     run;
        logic [`ELC_TS_W-1:0]     stamp;
        logic                     pend;
        elc_pkg::elc_rec_t        snap;
        logic                     wr_en;
        elc_pkg::elc_rec_t        wr_data;
        logic [`ELC_ADDR_W-1:0]   wr_ptr;
        logic [`ELC_CNT_W-1:0]    count;
        elc_pkg::elc_state_t      st;
        logic                     dump;
        logic [`ELC_ADDR_W-1:0]   rd_ptr;
        logic [`ELC_CNT_W-1:0]    left;
        logic [`ELC_REC_W-1:0]    word;
        logic [3:0]               nch;
        logic [7:0]               tx_data;
        logic                     tx_valid;
        logic [1:0]               inhib;
    } elc_core_t;

    elc_core_t         s_q;
    elc_core_t         s_d;
    elc_pkg::elc_rec_t rd_data;
    logic              chg;

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        hex_chr = (n < 4'ha) ? `ELC_CHR_ZERO + {4'h0, n} : `ELC_CHR_ALPHA + {4'h0, n};
    endfunction : hex_chr

    // Only locally wired signals reach this logger
    elc_mem u_mem (
        .sys_clk   (sys_clk),
        .wr_en     (s_q.wr_en),
        .wr_addr   (s_q.wr_ptr),
        .wr_data   (s_q.wr_data),
        .rd_addr   (s_q.rd_ptr),
        .rd_data_q (rd_data)
    );

    assign chg = (s_q.sync2 != s_q.prev);

    always_comb begin
        s_d       = s_q;
        s_d.sync1 = mon_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        s_d.inhib = 2'b00;
        s_d.pend  = 1'b0;
        s_d.wr_en = 1'b0;
        // Stamp runs only during capture, steps back only when its 32 bits wrap
        if (s_q.run) begin
            s_d.stamp = s_q.stamp + 32'h0000_0001;
        end
        // Gating edges kick the inhibit timers first
        if (s_q.run && chg) begin
            s_d.inhib = {s_q.sync2.beam_gate ^ s_q.prev.beam_gate,
                         s_q.sync2.rf_gate ^ s_q.prev.rf_gate};
            s_d.pend  = 1'b1;
            s_d.snap  = {s_q.sync2, s_q.stamp};
        end
        // Snapshot stored one cycle after the timer kick
        if (s_q.pend) begin
            s_d.wr_en   = 1'b1;
            s_d.wr_data = s_q.snap;
        end
        // Pointer wraps, count saturates at full depth
        if (s_q.wr_en) begin
            s_d.wr_ptr = s_q.wr_ptr + 12'h001;
            if (s_q.count != `ELC_DEPTH) begin
                s_d.count = s_q.count + 13'h0001;
            end
        end
        if (s_q.tx_valid && tx_ready) begin
            s_d.tx_valid = 1'b0;
        end
        // All control arrives over the byte stream
        case (s_q.st)
            elc_pkg::ST_IDLE: begin
                if (rx_valid) begin
                    case (rx_data)
                        `ELC_CMD_START: begin
                            s_d.run = 1'b1;
                        end
                        `ELC_CMD_STOP: begin
                            s_d.run = 1'b0;
                        end
                        `ELC_CMD_COUNT: begin
                            s_d.word = {3'b000, s_q.count, 32'h0000_0000};
                            s_d.nch  = `ELC_CNT_CHARS;
                            s_d.dump = 1'b0;
                            s_d.st   = elc_pkg::ST_SEND;
                        end
                        `ELC_CMD_DUMP: begin
                            // Oldest first; a full ring starts at the write pointer
                            s_d.rd_ptr = s_q.wr_ptr - s_q.count[`ELC_ADDR_W-1:0];
                            s_d.left   = s_q.count;
                            s_d.dump   = 1'b1;
                            s_d.st     = elc_pkg::ST_DL_ADDR;
                        end
                        default: begin
                            s_d.st = elc_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            elc_pkg::ST_DL_ADDR: begin
                if (s_q.left == 13'h0000) begin
                    s_d.nch  = 4'h0;
                    s_d.dump = 1'b0;
                    s_d.st   = elc_pkg::ST_SEND;
                end else begin
                    s_d.st = elc_pkg::ST_DL_LOAD;
                end
            end
            elc_pkg::ST_DL_LOAD: begin
                s_d.word   = rd_data;
                s_d.nch    = `ELC_REC_CHARS;
                s_d.rd_ptr = s_q.rd_ptr + 12'h001;
                s_d.left   = s_q.left - 13'h0001;
                s_d.st     = elc_pkg::ST_SEND;
            end
            elc_pkg::ST_SEND: begin
                if (!s_d.tx_valid) begin
                    s_d.tx_valid = 1'b1;
                    // Hex digits and separator only, all printable
                    if (s_q.nch != 4'h0) begin
                        s_d.tx_data = hex_chr(s_q.word[`ELC_REC_W-1 -: 4]);
                        s_d.word    = {s_q.word[`ELC_REC_W-5:0], 4'h0};
                        s_d.nch     = s_q.nch - 4'h1;
                    end else begin
                        s_d.tx_data = `ELC_CHR_SEP;
                        s_d.st      = s_q.dump ? elc_pkg::ST_DL_ADDR : elc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = elc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_data_q       = s_q.tx_data;
    assign tx_valid_q      = s_q.tx_valid;
    assign inhibit_start_q = s_q.inhib;
    assign logging_q       = s_q.run;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Back-to-back changes overlap one kick with the previous store
    sequence kick_s;
        s_q.pend;
    endsequence

    sequence store_s;
        s_q.wr_en;
    endsequence

    change_capture_a: assert property (
        (s_q.run && chg) |=> kick_s ##1 store_s)
        else $error("Change did not produce a record write");

    snap_value_a: assert property (
        (s_q.run && chg) |-> ##2 (s_q.wr_data.mon == $past(s_q.sync2, 2)
            && s_q.wr_data.stamp == $past(s_q.stamp, 2)))
        else $error("Stored snapshot differs from watched bits");

    ring_wrap_a: assert property (
        (s_q.wr_en && s_q.wr_ptr == `ELC_LAST_ADDR) |=> (s_q.wr_ptr == 12'h000))
        else $error("Write pointer did not wrap");

    count_limit_a: assert property (
        s_q.count <= `ELC_DEPTH)
        else $error("Stored count above depth");

    run_by_cmd_a: assert property (
        (s_q.run != $past(s_q.run)) |-> $past(rx_valid && s_q.st == elc_pkg::ST_IDLE
            && (rx_data == `ELC_CMD_START || rx_data == `ELC_CMD_STOP)))
        else $error("Capture changed without command");

    printable_tx_a: assert property (
        tx_valid_q |-> (tx_data_q >= `ELC_CHR_LO && tx_data_q <= `ELC_CHR_HI))
        else $error("Non-printable character sent");

    inhibit_first_a: assert property (
        (s_q.run && chg && (s_q.sync2.rf_gate != s_q.prev.rf_gate))
            |=> kick_s ##0 inhibit_start_q[0] ##1 store_s)
        else $error("Inhibit kick not ahead of snapshot");

    count_reply_a: assert property (
        (s_q.st == elc_pkg::ST_IDLE && rx_valid && rx_data == `ELC_CMD_COUNT && !tx_valid_q)
            |=> ##1 tx_valid_q)
        else $error("Count query not answered");

    stamp_step_a: assert property (
        ($past(s_q.run) && s_q.run) |-> (s_q.stamp == $past(s_q.stamp) + 32'h0000_0001))
        else $error("Timestamp not counting while capturing");

endmodule : elc_logger

//--- hdl/elc_mem.sv
/*
 * Record memory of the event logger, one write and one read port.
 * Assumes a single clock; read data appear one edge after the address.
 */
`timescale 1ns/10ps
`include "elc_map.svh"

module elc_mem (
    input  wire logic                   sys_clk,
    input  wire logic                   wr_en,
    input  wire logic [`ELC_ADDR_W-1:0] wr_addr,
    input  wire elc_pkg::elc_rec_t      wr_data,
    input  wire logic [`ELC_ADDR_W-1:0] rd_addr,
    output      elc_pkg::elc_rec_t      rd_data_q
);

    elc_pkg::elc_rec_t mem [0:(1 << `ELC_ADDR_W)-1];

    // No reset: stale words are never read, the count bounds the dump
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end

endmodule : elc_mem

//--- sim/elc_host_model.sv
/*
 * Remote scripting host: sends command bytes and collects reply characters.
 * Assumes the logger's clock; slow mode stalls tx_ready every other cycle.
 */
`timescale 1ns/10ps

module elc_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] tx_data_q,
    input  wire logic       tx_valid_q,
    output      logic [7:0] rx_data,
    output      logic       rx_valid,
    output      logic       tx_ready
);
    logic       slow = 1'b0;
    logic [7:0] reply [$];

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    // Taken only at the edge where ready is sampled high
    always @(posedge sys_clk) begin
        if (tx_valid_q === 1'b1 && tx_ready) begin
            reply.push_back(tx_data_q);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // One-cycle byte; line inverted after so a stale byte is never reread
    task automatic send(input logic [7:0] c);
        @(posedge sys_clk);
        rx_data  <= c;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask : send
endmodule : elc_host_model

//--- sim/elc_logger_tb.sv
/*
 * Self-checking bench of the event logger driven through a host model.
 * Assumes package, logger and host model compiled first; 100 MHz clock.
 */
`timescale 1ns/10ps
`include "elc_map.svh"

module elc_logger_tb;
    logic              sys_clk = 1'b0;
    logic              reset_n = 1'b0;
    elc_pkg::elc_mon_t mon_in  = '0;
    logic [7:0]        rx_data, tx_data_q;
    logic              rx_valid, tx_ready, tx_valid_q, logging_q;
    logic [1:0]        inhibit_start_q;
    int                n_fail  = 0;
    int                checked = 0;
    int                cyc     = 0;

    elc_logger u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .mon_in(mon_in), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
        .inhibit_start_q(inhibit_start_q), .logging_q(logging_q));
    elc_host_model u_host (.sys_clk(sys_clk), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic print_verdict;
        $display("Counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Ceiling well above the wrap fill of 8200 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check_str(input string what, input string exp, input string got);
        checked++;
        if (exp != got) begin
            n_fail++;
            $display("unexpected %s: expected %s, seen %s", what, exp, got);
        end
    endtask : check_str

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val

    // Idles after n chars so that any extra character shows up in the string
    task automatic get_reply(input int n, output string s);
        int k;
        k = 0;
        s = "";
        while (u_host.reply.size() < n && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        repeat (20) @(posedge sys_clk);
        foreach (u_host.reply[i]) s = {s, string'(u_host.reply[i])};
        u_host.reply.delete();
    endtask : get_reply

    task automatic query(input logic [7:0] cmd, input int n, input string exp);
        string s;
        u_host.send(cmd);
        get_reply(n, s);
        check_str("reply", exp, s);
    endtask : query

    // Flips watched bits; counts inhibit kicks per gate over the capture latency
    task automatic flip(input logic [15:0] f, input logic [1:0] exp);
        int nb, nr;
        nb = 0;
        nr = 0;
        @(posedge sys_clk);
        mon_in <= mon_in ^ f;
        repeat (10) begin
            @(posedge sys_clk);
            #1;
            if (inhibit_start_q[1] === 1'b1) nb++;
            if (inhibit_start_q[0] === 1'b1) nr++;
        end
        check_val("beam kicks", 32'(exp[1]), 32'(nb));
        check_val("rf kicks", 32'(exp[0]), 32'(nr));
    endtask : flip

    task automatic sc_idle;
        string s;
        #1;
        check_val("logging", 0, logging_q);
        flip(16'h0001, 2'b00);
        flip(16'h0001, 2'b00);
        query(8'h58, 0, "");
        query(`ELC_CMD_COUNT, 5, "0000;");
        query(`ELC_CMD_DUMP, 1, ";");
        u_host.send(`ELC_CMD_COUNT);
        u_host.send(`ELC_CMD_COUNT);
        get_reply(5, s);
        check_str("busy reply", "0000;", s);
    endtask : sc_idle

    task automatic sc_capture;
        string s;
        logic [31:0] t0, t1, t2;
        u_host.send(`ELC_CMD_START);
        @(posedge sys_clk);
        #1;
        check_val("logging", 1, logging_q);
        flip(16'h4000, 2'b01);
        flip(16'h8000, 2'b10);
        flip(16'h0001, 2'b00);
        check_val("logging", 1, logging_q);
        u_host.send(`ELC_CMD_STOP);
        repeat (2) @(posedge sys_clk);
        #1;
        check_val("logging", 0, logging_q);
        query(`ELC_CMD_COUNT, 5, "0003;");
        u_host.slow = 1'b1;
        u_host.send(`ELC_CMD_DUMP);
        get_reply(40, s);
        u_host.slow = 1'b0;
        check_val("dump length", 40, s.len());
        check_str("rec0", "4000", s.substr(0, 3));
        check_str("rec1", "C000", s.substr(13, 16));
        check_str("rec2", "C001", s.substr(26, 29));
        check_str("seps", ";;;;", {s.substr(12, 12), s.substr(25, 25), s.substr(38, 39)});
        t0 = s.substr(4, 11).atohex();
        t1 = s.substr(17, 24).atohex();
        t2 = s.substr(30, 37).atohex();
        check_val("stamp step", 11, t1 - t0);
        check_val("stamp step", 11, t2 - t1);
    endtask : sc_capture

    // Full dump after wrap would exceed the run budget; count only
    task automatic sc_wrap;
        u_host.send(`ELC_CMD_START);
        repeat (4100) begin
            @(posedge sys_clk);
            mon_in <= mon_in ^ 16'h0002;
            @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        u_host.send(`ELC_CMD_STOP);
        query(`ELC_CMD_COUNT, 5, "1000;");
    endtask : sc_wrap

    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sc_idle();
        sc_capture();
        sc_wrap();
        print_verdict();
    end
endmodule : elc_logger_tb
